// ===== rtl/vcsc_pkg.sv
// Constants, types and helpers for the variable clock source control block
//
// Summary of operation
// RULE1: The first variable clock comes from a 4-bit divider whose ratio is the field value plus one, from 1 to 16.
// RULE2: The first divider counts the internal 24 MHz clock, or the external clock input when external clocking is selected.
// RULE3: The first divider ratio sits in bits 7:4 of the divider control register, 0h meaning divide by one and Fh by sixteen.
// RULE4: The second variable clock divides the first one again by the bits 3:0 field plus one.
// RULE5: Bit 7 of the oscillator source control register holds the PLL in low gain, and no other bit of it touches the PLL.
// RULE6: Bit 2 of the oscillator source control register moves the system clock tree from the internal oscillator to the external clock.
// RULE7: Outside signals, the 32 kHz clock among them, are resynchronised to the currently selected system clock source.
// RULE8: Software should keep PLL mode off while the external clock drives the system clock tree.
// RULE9: Bit 1 of the oscillator source control register turns the internal main oscillator off, unless the doubler overrides it.
// RULE10: While the doubler disable bit is zero the internal main oscillator is forced on.
// RULE11: Bit 0 of the oscillator source control register turns the doubler off.
// RULE12: Bits 6 to 3 of the oscillator source control register are reserved and do nothing.
// RULE13: Both registers reset to zero: divide by one, internal source, normal PLL gain, doubler on.
package vcsc_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_DIV_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_OSC_CTRL = 12'h004;
   localparam logic [REG_W-1:0] DIV_CTRL_RESET = 8'h00;
   localparam logic [REG_W-1:0] OSC_CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int unsigned FIRST_HI = 7;
   localparam int unsigned FIRST_LO = 4;
   localparam int unsigned SECOND_HI = 3;
   localparam int unsigned SECOND_LO = 0;
   localparam int unsigned PLL_GAIN_BIT = 7;
   localparam int unsigned EXT_SEL_BIT = 2;
   localparam int unsigned MO_DIS_BIT = 1;
   localparam int unsigned DBL_DIS_BIT = 0;
   localparam int unsigned RATIO_W = 4;
   localparam logic [RATIO_W-1:0] RATIO_DIV1 = 4'h0;
   localparam logic [RATIO_W-1:0] COUNT_ONE = 4'h1;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic [RATIO_W-1:0] first_ratio;
      logic [RATIO_W-1:0] second_ratio;
   } vcsc_div_ctrl_type;

   typedef struct packed {
      logic pll_low_gain;
      logic ext_sel;
      logic mo_dis;
      logic dbl_dis;
   } vcsc_osc_ctrl_type;

   typedef struct packed {
      logic pll_low_gain_select;
      logic external_clock_select;
      logic main_osc_enable;
      logic doubler_enable;
   } vcsc_osc_out_type;

   // ***************************************************************
   // Divider helpers
   // ***************************************************************
   function automatic logic [RATIO_W-1:0] vcsc_next_count(
      input logic [RATIO_W-1:0] cnt,
      input logic [RATIO_W-1:0] ratio);
      return (cnt >= ratio) ? RATIO_DIV1 : cnt + COUNT_ONE;
   endfunction

   function automatic logic vcsc_high_phase(
      input logic [RATIO_W-1:0] cnt,
      input logic [RATIO_W-1:0] ratio);
      return cnt <= (ratio >> 1);
   endfunction

endpackage

// ===== rtl/vcsc_divider.sv
// Edge-counting divide-by-(ratio+1) stage for one variable clock
`timescale 1ns/1ns
module vcsc_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_level,
   input wire logic in_rise,
   input wire logic [vcsc_pkg::RATIO_W-1:0] ratio,
   output logic out_level,
   output logic out_rise
);

   logic [vcsc_pkg::RATIO_W-1:0] cnt;
   logic [vcsc_pkg::RATIO_W-1:0] next_cnt;

   assign next_cnt = vcsc_pkg::vcsc_next_count(cnt, ratio);

   // ***************************************************************
   // Input edge counter
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= vcsc_pkg::RATIO_DIV1;
      end else if (in_rise) begin
         cnt <= next_cnt; // RULE1
      end
   end

   // ***************************************************************
   // Output clock and tick
   // ***************************************************************
   // Ratio zero passes the source through; even ratios run long high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_level <= 1'b0;
      end else if (ratio == vcsc_pkg::RATIO_DIV1) begin
         out_level <= in_level; // RULE1
      end else if (in_rise) begin
         out_level <= vcsc_pkg::vcsc_high_phase(next_cnt, ratio); // RULE1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_rise <= 1'b0;
      end else begin
         out_rise <= in_rise && (cnt >= ratio); // RULE1
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_div_tick;
      @(posedge pclk) disable iff (!presetn)
         (in_rise && cnt == ratio) |=> out_rise;
   endproperty
   a_div_tick: assert property (p_div_tick) // RULE1
      else $error("divider missed its tick");

   property p_div_no_early;
      @(posedge pclk) disable iff (!presetn)
         (in_rise && cnt < ratio) |=> !out_rise;
   endproperty
   a_div_no_early: assert property (p_div_no_early) // RULE1
      else $error("divider ticked before ratio reached");

endmodule

// ===== rtl/vcsc_top.sv
// Variable clock source control: APB registers, source select, dividers
`timescale 1ns/1ns
module vcsc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [vcsc_pkg::ADDR_W-1:0] paddr,
   input wire logic [vcsc_pkg::DATA_W-1:0] pwdata,
   output logic [vcsc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic main_oscillator_clock,
   input wire logic external_clock_input,
   input wire logic slow_clock_32k,
   output logic system_clock_tree,
   output logic system_clock_tick,
   output logic first_variable_clock,
   output logic first_variable_clock_tick,
   output logic second_variable_clock,
   output logic second_variable_clock_tick,
   output logic slow_clock_resync,
   output vcsc_pkg::vcsc_osc_out_type osc_ctrl
);

   // ***************************************************************
   // Registers and bus decode
   // ***************************************************************
   vcsc_pkg::vcsc_div_ctrl_type div_ctrl;
   vcsc_pkg::vcsc_osc_ctrl_type osc_src;
   logic setup_phase;
   logic access_phase;
   logic hit_div;
   logic hit_osc;
   logic unmapped;
   logic wr_div;
   logic wr_osc;
   logic [vcsc_pkg::DATA_W-1:0] next_prdata;

   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign hit_div = (paddr == vcsc_pkg::ADDR_DIV_CTRL);
   assign hit_osc = (paddr == vcsc_pkg::ADDR_OSC_CTRL);
   assign unmapped = !hit_div && !hit_osc;
   assign wr_div = access_phase && pwrite && hit_div;
   assign wr_osc = access_phase && pwrite && hit_osc;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access_phase && unmapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ctrl <= vcsc_pkg::DIV_CTRL_RESET; // RULE13
      end else if (wr_div) begin
         div_ctrl.first_ratio <=
            pwdata[vcsc_pkg::FIRST_HI:vcsc_pkg::FIRST_LO]; // RULE3
         div_ctrl.second_ratio <=
            pwdata[vcsc_pkg::SECOND_HI:vcsc_pkg::SECOND_LO]; // RULE4
      end
   end

   // Reserved bits have no storage at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_src <= {vcsc_pkg::OSC_CTRL_RESET[vcsc_pkg::PLL_GAIN_BIT],
            vcsc_pkg::OSC_CTRL_RESET[vcsc_pkg::EXT_SEL_BIT],
            vcsc_pkg::OSC_CTRL_RESET[vcsc_pkg::MO_DIS_BIT],
            vcsc_pkg::OSC_CTRL_RESET[vcsc_pkg::DBL_DIS_BIT]}; // RULE13
      end else if (wr_osc) begin
         osc_src.pll_low_gain <= pwdata[vcsc_pkg::PLL_GAIN_BIT]; // RULE5
         osc_src.ext_sel <= pwdata[vcsc_pkg::EXT_SEL_BIT]; // RULE6
         osc_src.mo_dis <= pwdata[vcsc_pkg::MO_DIS_BIT]; // RULE9
         osc_src.dbl_dis <= pwdata[vcsc_pkg::DBL_DIS_BIT]; // RULE11
      end
   end

   // Read data is prepared in the setup cycle
   always_comb begin
      next_prdata = vcsc_pkg::READ_ZERO;
      if (hit_div) begin
         next_prdata[vcsc_pkg::FIRST_HI:vcsc_pkg::FIRST_LO] =
            div_ctrl.first_ratio;
         next_prdata[vcsc_pkg::SECOND_HI:vcsc_pkg::SECOND_LO] =
            div_ctrl.second_ratio;
      end else if (hit_osc) begin
         next_prdata[vcsc_pkg::PLL_GAIN_BIT] = osc_src.pll_low_gain;
         next_prdata[vcsc_pkg::EXT_SEL_BIT] = osc_src.ext_sel;
         next_prdata[vcsc_pkg::MO_DIS_BIT] = osc_src.mo_dis;
         next_prdata[vcsc_pkg::DBL_DIS_BIT] = osc_src.dbl_dis; // RULE12
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= vcsc_pkg::READ_ZERO;
      end else if (setup_phase && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ***************************************************************
   // Oscillator control outputs
   // ***************************************************************
   // Software keeps PLL low gain off with the external source; RULE8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_ctrl <= '0;
      end else begin
         osc_ctrl.pll_low_gain_select <= osc_src.pll_low_gain; // RULE5
         osc_ctrl.external_clock_select <= osc_src.ext_sel; // RULE6
         osc_ctrl.main_osc_enable <=
            !osc_src.mo_dis || !osc_src.dbl_dis; // RULE9 RULE10
         osc_ctrl.doubler_enable <= !osc_src.dbl_dis; // RULE11
      end
   end

   // ***************************************************************
   // Source synchronisers
   // ***************************************************************
   logic int_s1;
   logic int_s2;
   logic int_s3;
   logic ext_s1;
   logic ext_s2;
   logic ext_s3;
   logic slow_s1;
   logic slow_s2;
   logic int_rise;
   logic ext_rise;
   logic src_level;
   logic src_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_s1 <= 1'b0;
         int_s2 <= 1'b0;
         int_s3 <= 1'b0;
      end else begin
         int_s1 <= main_oscillator_clock;
         int_s2 <= int_s1;
         int_s3 <= int_s2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= external_clock_input;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_s1 <= 1'b0;
         slow_s2 <= 1'b0;
      end else begin
         slow_s1 <= slow_clock_32k;
         slow_s2 <= slow_s1;
      end
   end

   assign int_rise = int_s2 && !int_s3;
   assign ext_rise = ext_s2 && !ext_s3;
   assign src_level = osc_src.ext_sel ? ext_s2 : int_s2; // RULE2 RULE6
   assign src_rise = osc_src.ext_sel ? ext_rise : int_rise; // RULE2

   // ***************************************************************
   // System clock tree and resynchronised slow clock
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_clock_tree <= 1'b0;
         system_clock_tick <= 1'b0;
      end else begin
         system_clock_tree <= src_level; // RULE6
         system_clock_tick <= src_rise; // RULE6
      end
   end

   // The slow clock only moves on a rising edge of the selected source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_clock_resync <= 1'b0;
      end else if (src_rise) begin
         slow_clock_resync <= slow_s2; // RULE7
      end
   end

   // ***************************************************************
   // Variable clock dividers
   // ***************************************************************
   vcsc_divider u_first_div (
      .pclk(pclk),
      .presetn(presetn),
      .in_level(src_level),
      .in_rise(src_rise),
      .ratio(div_ctrl.first_ratio),
      .out_level(first_variable_clock),
      .out_rise(first_variable_clock_tick)
   ); // RULE1 RULE2

   vcsc_divider u_second_div (
      .pclk(pclk),
      .presetn(presetn),
      .in_level(first_variable_clock),
      .in_rise(first_variable_clock_tick),
      .ratio(div_ctrl.second_ratio),
      .out_level(second_variable_clock),
      .out_rise(second_variable_clock_tick)
   ); // RULE4

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_source_select;
      @(posedge pclk) disable iff (!presetn)
         src_rise |=> first_variable_clock_tick
            || (div_ctrl.first_ratio != vcsc_pkg::RATIO_DIV1)
            || $past(wr_div);
   endproperty
   a_source_select: assert property (p_source_select) // RULE2
      else $error("divide-by-one first clock missed a source edge");

   property p_first_field;
      @(posedge pclk) disable iff (!presetn)
         wr_div |=> div_ctrl.first_ratio ==
            $past(pwdata[vcsc_pkg::FIRST_HI:vcsc_pkg::FIRST_LO]);
   endproperty
   a_first_field: assert property (p_first_field) // RULE3
      else $error("first ratio not taken from upper nibble");

   property p_second_field;
      @(posedge pclk) disable iff (!presetn)
         wr_div |=> div_ctrl.second_ratio ==
            $past(pwdata[vcsc_pkg::SECOND_HI:vcsc_pkg::SECOND_LO]);
   endproperty
   a_second_field: assert property (p_second_field) // RULE4
      else $error("second ratio not taken from lower nibble");

   property p_pll_gain;
      @(posedge pclk) disable iff (!presetn)
         wr_osc ##1 1'b1 |=> osc_ctrl.pll_low_gain_select ==
            $past(pwdata[vcsc_pkg::PLL_GAIN_BIT], 2);
   endproperty
   a_pll_gain: assert property (p_pll_gain) // RULE5
      else $error("pll low gain does not follow bit 7");

   property p_tree_source;
      @(posedge pclk) disable iff (!presetn)
         osc_src.ext_sel && $stable(osc_src.ext_sel)
            |=> system_clock_tree == $past(ext_s2);
   endproperty
   a_tree_source: assert property (p_tree_source) // RULE6
      else $error("system clock tree not on external clock");

   property p_slow_resync;
      @(posedge pclk) disable iff (!presetn)
         !src_rise |=> $stable(slow_clock_resync);
   endproperty
   a_slow_resync: assert property (p_slow_resync) // RULE7
      else $error("slow clock moved off a system clock edge");

   property p_osc_enable;
      @(posedge pclk) disable iff (!presetn)
         presetn && $stable(osc_src) ##1 1'b1
            |-> osc_ctrl.main_osc_enable ==
            !($past(osc_src.mo_dis) && $past(osc_src.dbl_dis));
   endproperty
   a_osc_enable: assert property (p_osc_enable) // RULE9
      else $error("main oscillator enable wrong");

   property p_doubler_forces_osc;
      @(posedge pclk) disable iff (!presetn)
         presetn && !osc_src.dbl_dis |=> osc_ctrl.main_osc_enable
            && osc_ctrl.doubler_enable;
   endproperty
   a_doubler_forces_osc: assert property (p_doubler_forces_osc) // RULE10
      else $error("doubler on but main oscillator off");

   property p_doubler_off;
      @(posedge pclk) disable iff (!presetn)
         osc_src.dbl_dis |=> !osc_ctrl.doubler_enable;
   endproperty
   a_doubler_off: assert property (p_doubler_off) // RULE11
      else $error("doubler not disabled");

   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
         (setup_phase && !pwrite && hit_osc)
            |=> prdata[vcsc_pkg::PLL_GAIN_BIT-1:vcsc_pkg::EXT_SEL_BIT+1]
               == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // RULE12
      else $error("reserved bits read nonzero");

   property p_reset_zero;
      @(posedge pclk) $rose(presetn)
         |-> div_ctrl == vcsc_pkg::DIV_CTRL_RESET && osc_src == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero) // RULE13
      else $error("registers not zero after reset");

endmodule

// ===== verification/vcsc_top_tb.sv
// Self-checking testbench for the variable clock source control block
`timescale 1ns/1ns
module vcsc_top_tb;
   // ***************************************************************
   // Stimulus and observed signals
   // ***************************************************************
   localparam int LIMIT = 20000;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [vcsc_pkg::ADDR_W-1:0] paddr;
   logic [vcsc_pkg::DATA_W-1:0] pwdata;
   logic [vcsc_pkg::DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic main_oscillator_clock;
   logic external_clock_input;
   logic slow_clock_32k;
   logic system_clock_tree;
   logic system_clock_tick;
   logic first_variable_clock;
   logic first_variable_clock_tick;
   logic second_variable_clock;
   logic second_variable_clock_tick;
   logic slow_clock_resync;
   vcsc_pkg::vcsc_osc_out_type osc_ctrl;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   int mcnt = 0;
   int ecnt = 0;
   int scnt = 0;
   logic [31:0] rd;
   logic err;
   int gap;
   int hi;
   logic [7:0] wtab [6] = '{8'h80, 8'h78, 8'h04, 8'h02, 8'h03, 8'h01};
   logic [7:0] rtab [6] = '{8'h80, 8'h00, 8'h04, 8'h02, 8'h03, 8'h01};
   logic [3:0] otab [6] = '{4'hb, 4'h3, 4'h7, 4'h3, 4'h0, 4'h2};

   vcsc_top vcsc_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .main_oscillator_clock(main_oscillator_clock),
      .external_clock_input(external_clock_input),
      .slow_clock_32k(slow_clock_32k),
      .system_clock_tree(system_clock_tree),
      .system_clock_tick(system_clock_tick),
      .first_variable_clock(first_variable_clock),
      .first_variable_clock_tick(first_variable_clock_tick),
      .second_variable_clock(second_variable_clock),
      .second_variable_clock_tick(second_variable_clock_tick),
      .slow_clock_resync(slow_clock_resync), .osc_ctrl(osc_ctrl)
   );

   // ***************************************************************
   // Clock, source clocks and timeout
   // ***************************************************************
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Internal source period 6 cycles, external 8, slow 80
   always @(posedge pclk) begin
      mcnt <= (mcnt == 5) ? 0 : mcnt + 1;
      ecnt <= (ecnt == 7) ? 0 : ecnt + 1;
      scnt <= (scnt == 79) ? 0 : scnt + 1;
      main_oscillator_clock <= (mcnt < 3);
      external_clock_input <= (ecnt < 4);
      slow_clock_32k <= (scnt < 40);
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         $display("Error timeout after %0d cycles", cycles);
         miscompares++;
         stop_test();
      end
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic tick_of(input int w);
      if (w == 0) return system_clock_tick;
      if (w == 1) return first_variable_clock_tick;
      return second_variable_clock_tick;
   endfunction

   function automatic logic level_of(input int w);
      if (w == 0) return system_clock_tree;
      if (w == 1) return first_variable_clock;
      return second_variable_clock;
   endfunction

   // Settles on the third tick, so the gap is a full steady period
   task automatic tick_gap(input int w, output int g);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         hi = 0;
         do begin
            @(negedge pclk);
            n++;
            if (level_of(w) === 1'b1) begin
               hi++;
            end
         end while (tick_of(w) !== 1'b1 && n < 2000);
         g = n;
      end
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(negedge pclk);
      check("osc_ctrl reset", 32'h3, {28'h0, osc_ctrl});
      apb(1'b0, vcsc_pkg::ADDR_DIV_CTRL, 32'h0, rd, err);
      check("div reset", 32'h0, rd);
      apb(1'b0, vcsc_pkg::ADDR_OSC_CTRL, 32'h0, rd, err);
      check("osc reset", 32'h0, rd);
      $display("reset test done");

      apb(1'b1, vcsc_pkg::ADDR_DIV_CTRL, 32'hffff_ffa5, rd, err);
      apb(1'b0, vcsc_pkg::ADDR_DIV_CTRL, 32'h0, rd, err);
      check("div readback", 32'ha5, rd);
      apb(1'b0, 12'h008, 32'h0, rd, err);
      check("unmapped err", 32'h1, {31'h0, err});
      check("unmapped data", 32'h0, rd);
      $display("register test done");

      for (int i = 0; i < 6; i++) begin
         apb(1'b1, vcsc_pkg::ADDR_OSC_CTRL, {24'h0, wtab[i]}, rd, err);
         repeat (2) @(negedge pclk);
         check("osc_ctrl", {28'h0, otab[i]}, {28'h0, osc_ctrl});
         apb(1'b0, vcsc_pkg::ADDR_OSC_CTRL, 32'h0, rd, err);
         check("osc readback", {24'h0, rtab[i]}, rd);
      end
      apb(1'b1, vcsc_pkg::ADDR_OSC_CTRL, 32'h0, rd, err);
      $display("oscillator control test done");

      tick_gap(0, gap);
      check("internal source gap", 32'd6, gap);
      check("tree high", 32'd3, hi);
      for (int r = 0; r < 16; r++) begin
         apb(1'b1, vcsc_pkg::ADDR_DIV_CTRL, r << 4, rd, err);
         tick_gap(1, gap);
         check("first clock gap", (r + 1) * 6, gap);
         check("first clock high", (r == 0) ? 3 : (r / 2 + 1) * 6,
               hi);
      end
      apb(1'b1, vcsc_pkg::ADDR_DIV_CTRL, 32'h10, rd, err);
      tick_gap(2, gap);
      check("second clock gap", 32'd12, gap);
      check("second clock high", 32'd6, hi);
      apb(1'b1, vcsc_pkg::ADDR_DIV_CTRL, 32'h1f, rd, err);
      tick_gap(2, gap);
      check("second clock gap", 32'd192, gap);
      check("second clock high", 32'd96, hi);
      $display("divider test done");

      // External source with the PLL left in normal gain
      apb(1'b1, vcsc_pkg::ADDR_OSC_CTRL, 32'h04, rd, err);
      apb(1'b1, vcsc_pkg::ADDR_DIV_CTRL, 32'h20, rd, err);
      tick_gap(0, gap);
      check("external source gap", 32'd8, gap);
      check("external tree high", 32'd4, hi);
      tick_gap(1, gap);
      check("external first gap", 32'd24, gap);
      check("external first high", 32'd16, hi);
      for (int k = 0; k < 2; k++) begin
         while (scnt != 20 && scnt != 60) @(negedge pclk);
         check("slow resync", {31'h0, slow_clock_32k},
               {31'h0, slow_clock_resync});
         @(negedge pclk);
      end
      $display("external source test done");
      stop_test();
   end
endmodule
